// File: include/srg_pkg.sv
package srg_pkg;

   // ----------------------------------------------------------------
   // Register map (word index, byte address is four times the index)
   // ----------------------------------------------------------------
   localparam int ADDR_W = 10;
   localparam logic [7:0] IDX_RESET_CTRL = 8'h19;
   localparam logic [7:0] IDX_GAIN_LOAD = 8'h1a;
   localparam logic [7:0] IDX_CONFIG = 8'h1b;
   localparam logic [7:0] IDX_STATUS = 8'h30;
   localparam logic [7:0] IDX_MASK = 8'h31;
   localparam logic [7:0] IDX_STATE = 8'h32;
   localparam logic [7:0] IDX_ACC = 8'h33;
   localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
   localparam logic [31:0] READ_ZERO = 32'h0000_0000;
   localparam int CFG_AGC_CLR_INHIBIT = 15;

   // ----------------------------------------------------------------
   // Reset pulse lengths in periods of each domain's clock
   // ----------------------------------------------------------------
   localparam logic [3:0] RESET_PERIODS = 4'ha;
   localparam logic [3:0] CNT_ONE = 4'h1;
   localparam logic [3:0] CNT_ZERO = 4'h0;

   // ----------------------------------------------------------------
   // Gain load word fields
   // ----------------------------------------------------------------
   localparam int LOAD_MSB = 15;
   localparam int LOAD_LSB = 5;
   localparam int LOAD_W = LOAD_MSB - LOAD_LSB + 1;
   localparam int ACC_W = 32;
   localparam int EXP_W = 4;
   localparam int MANT_W = 7;
   localparam logic [1:0] MANT_INT = 2'b01;
   localparam logic [ACC_W-LOAD_W-1:0] ACC_LOW_ZERO = '0;

   // ----------------------------------------------------------------
   // Status bits, FIFO presets
   // ----------------------------------------------------------------
   localparam int ST_W = 3;
   localparam int ST_FE_DONE = 0;
   localparam int ST_BE_DONE = 1;
   localparam int ST_GAIN_LOADED = 2;
   localparam logic [2:0] FIFO_RD_PTR_INIT = 3'h7;
   localparam logic [2:0] FIFO_WR_PTR_INIT = 3'h0;

   typedef enum logic [1:0] {
      SRG_BUS_IDLE = 2'b01,
      SRG_BUS_ACK = 2'b10
   } srg_bus_e;

   typedef struct packed {
      logic decoder_clear;
      logic [2:0] rd_ptr;
      logic [2:0] wr_ptr;
      logic depth;
      logic full;
      logic empty;
      logic read_out;
      logic fifo_interrupt;
   } srg_fifo_ctl_s;

   typedef struct packed {
      logic cordic_clear;
      logic snap_clear;
      logic serial_reload;
   } srg_be_clear_s;

   typedef struct packed {
      logic [EXP_W-1:0] exponent;
      logic [MANT_W+1:0] mantissa;
   } srg_gain_s;

   typedef struct packed {
      srg_bus_e bus;
      logic waitreq;
      logic [31:0] readdata;
      logic fe_clk_q;
      logic be_clk_q;
      logic fe_pend;
      logic be_pend;
      logic gain_pend;
      logic acc_clr_pend;
      logic acc_clr;
      logic [3:0] fe_cnt;
      logic [3:0] be_cnt;
      logic fe_rst;
      logic be_rst;
      logic gain_strobe;
      logic [LOAD_W-1:0] gain_word;
      logic [ACC_W-1:0] acc;
      logic [31:0] config_word;
      logic [ST_W-1:0] status;
      logic [ST_W-1:0] mask;
      logic irq;
      srg_be_clear_s be_clear;
      srg_fifo_ctl_s fifo_ctl;
   } srg_state_s;

endpackage

// File: src/srg_soft_reset.sv
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module srg_soft_reset (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic [srg_pkg::ADDR_W-1:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic front_end_clock_in,
   input wire logic back_end_clock_in,
   input wire logic [srg_pkg::ACC_W-1:0] agc_limiter_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic front_end_reset_out,
   output logic back_end_reset_out,
   output logic gain_load_strobe_out,
   output logic [srg_pkg::ACC_W-1:0] agc_acc_out,
   output srg_pkg::srg_gain_s agc_gain_out,
   output srg_pkg::srg_be_clear_s be_clear_out,
   output srg_pkg::srg_fifo_ctl_s fifo_ctl_out,
   output logic irq_out
);

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic [31:0] lane_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic is_reg(input logic [srg_pkg::ADDR_W-1:0] addr, input logic [7:0] idx);
      return (addr[1:0] == 2'b00) && (addr[srg_pkg::ADDR_W-1:2] == idx);
   endfunction

   // ----------------------------------------------------------------
   // Reset pulse counters
   // ----------------------------------------------------------------
   function automatic logic [3:0] count_down(input logic [3:0] cnt);
      return (cnt == srg_pkg::CNT_ZERO) ? srg_pkg::CNT_ZERO : cnt - srg_pkg::CNT_ONE;
   endfunction

   function automatic logic is_last(input logic [3:0] cnt);
      return cnt == srg_pkg::CNT_ONE;
   endfunction

   srg_pkg::srg_state_s st;
   srg_pkg::srg_state_s next_st;

   logic fe_rise;
   logic be_rise;
   logic bus_take;
   logic wr_take;
   logic [31:0] wr_data;
   logic [srg_pkg::ST_W-1:0] st_set;
   logic [srg_pkg::ST_W-1:0] st_clr;
   logic hit_reset;
   logic hit_gain;
   logic hit_config;
   logic hit_status;
   logic hit_mask;
   logic hit_state;
   logic hit_acc;
   logic acc_clear_now;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      next_st = st;
      fe_rise = front_end_clock_in & ~st.fe_clk_q;
      be_rise = back_end_clock_in & ~st.be_clk_q;
      next_st.fe_clk_q = front_end_clock_in;
      next_st.be_clk_q = back_end_clock_in;
      bus_take = 1'b0;
      wr_take = 1'b0;
      wr_data = lane_merge(srg_pkg::READ_ZERO, avs_writedata_in, avs_byteenable_in);
      st_set = '0;
      st_clr = '0;
      acc_clear_now = 1'b0;

      // ----------------------------------------------------------------
      // Address decode
      // ----------------------------------------------------------------
      hit_reset = is_reg(avs_address_in, srg_pkg::IDX_RESET_CTRL);
      hit_gain = is_reg(avs_address_in, srg_pkg::IDX_GAIN_LOAD);
      hit_config = is_reg(avs_address_in, srg_pkg::IDX_CONFIG);
      hit_status = is_reg(avs_address_in, srg_pkg::IDX_STATUS);
      hit_mask = is_reg(avs_address_in, srg_pkg::IDX_MASK);
      hit_state = is_reg(avs_address_in, srg_pkg::IDX_STATE);
      hit_acc = is_reg(avs_address_in, srg_pkg::IDX_ACC);

      // ----------------------------------------------------------------
      // Bus slave, one wait cycle
      // ----------------------------------------------------------------
      case (st.bus)
         srg_pkg::SRG_BUS_IDLE: begin
            next_st.waitreq = 1'b1;
            if (avs_read_in || avs_write_in) begin
               bus_take = 1'b1;
               wr_take = avs_write_in;
               next_st.bus = srg_pkg::SRG_BUS_ACK;
               next_st.waitreq = 1'b0;
            end
         end
         srg_pkg::SRG_BUS_ACK: begin
            next_st.bus = srg_pkg::SRG_BUS_IDLE;
            next_st.waitreq = 1'b1;
         end
         default: begin
            next_st.bus = srg_pkg::SRG_BUS_IDLE;
            next_st.waitreq = 1'b1;
         end
      endcase

      // ----------------------------------------------------------------
      // Read data
      // ----------------------------------------------------------------
      if (bus_take && avs_read_in) begin
         if (hit_config) begin
            next_st.readdata = st.config_word;
         end else if (hit_status) begin
            next_st.readdata = {29'h0000_0000, st.status};
         end else if (hit_mask) begin
            next_st.readdata = {29'h0000_0000, st.mask};
         end else if (hit_state) begin
            next_st.readdata = {26'h000_0000, st.fe_rst, st.be_rst, st.fe_pend, st.be_pend,
                                st.gain_pend, st.gain_strobe};
         end else if (hit_acc) begin
            next_st.readdata = st.acc;
         end else begin
            next_st.readdata = srg_pkg::READ_ZERO;
         end
      end

      // ----------------------------------------------------------------
      // Register writes
      // ----------------------------------------------------------------
      if (wr_take) begin
         if (hit_reset) begin
            next_st.fe_pend = 1'b1;
            next_st.be_pend = 1'b1;
            next_st.acc_clr_pend = ~st.config_word[srg_pkg::CFG_AGC_CLR_INHIBIT];
         end
         if (hit_gain) begin
            next_st.gain_word = wr_data[srg_pkg::LOAD_MSB:srg_pkg::LOAD_LSB];
            next_st.gain_pend = 1'b1;
         end
         if (hit_config) begin
            next_st.config_word = lane_merge(st.config_word, avs_writedata_in, avs_byteenable_in);
         end
         if (hit_mask) begin
            next_st.mask = wr_data[srg_pkg::ST_W-1:0];
         end
         if (hit_status) begin
            st_clr = wr_data[srg_pkg::ST_W-1:0];
         end
      end

      // ----------------------------------------------------------------
      // Front-end reset stretch
      // ----------------------------------------------------------------
      if (fe_rise) begin
         if (st.fe_pend) begin
            next_st.fe_pend = 1'b0;
            next_st.fe_cnt = srg_pkg::RESET_PERIODS;
         end else if (st.fe_cnt != srg_pkg::CNT_ZERO) begin
            next_st.fe_cnt = count_down(st.fe_cnt);
            st_set[srg_pkg::ST_FE_DONE] = is_last(st.fe_cnt);
         end
      end
      next_st.fe_rst = (next_st.fe_cnt != srg_pkg::CNT_ZERO);

      // ----------------------------------------------------------------
      // Back-end reset stretch, gain strobe, accumulator
      // ----------------------------------------------------------------
      if (be_rise) begin
         if (st.be_pend) begin
            next_st.be_pend = 1'b0;
            next_st.be_cnt = srg_pkg::RESET_PERIODS;
            next_st.acc_clr = st.acc_clr_pend;
            next_st.acc_clr_pend = 1'b0;
         end else if (st.be_cnt != srg_pkg::CNT_ZERO) begin
            next_st.be_cnt = count_down(st.be_cnt);
            st_set[srg_pkg::ST_BE_DONE] = is_last(st.be_cnt);
         end
         next_st.gain_strobe = st.gain_pend;
         if (st.gain_pend) begin
            next_st.gain_pend = 1'b0;
         end
         st_set[srg_pkg::ST_GAIN_LOADED] = st.gain_pend;
         acc_clear_now = (next_st.be_cnt != srg_pkg::CNT_ZERO) && next_st.acc_clr;
         if (acc_clear_now) begin
            next_st.acc = '0;
         end else if (next_st.gain_strobe) begin
            next_st.acc = {next_st.gain_word, srg_pkg::ACC_LOW_ZERO};
         end else begin
            next_st.acc = agc_limiter_in;
         end
         if (next_st.be_cnt == srg_pkg::CNT_ZERO) begin
            next_st.acc_clr = 1'b0;
         end
      end
      next_st.be_rst = (next_st.be_cnt != srg_pkg::CNT_ZERO);

      // ----------------------------------------------------------------
      // Back-end subsystem clears
      // ----------------------------------------------------------------
      next_st.be_clear.cordic_clear = next_st.be_rst;
      next_st.be_clear.snap_clear = next_st.be_rst;
      next_st.be_clear.serial_reload = next_st.be_rst;
      next_st.fifo_ctl.decoder_clear = next_st.be_rst;
      if (next_st.be_rst) begin
         next_st.fifo_ctl.read_out = 1'b0;
         next_st.fifo_ctl.fifo_interrupt = 1'b0;
         next_st.fifo_ctl.depth = 1'b0;
         next_st.fifo_ctl.full = 1'b0;
         next_st.fifo_ctl.empty = 1'b1;
         next_st.fifo_ctl.rd_ptr = srg_pkg::FIFO_RD_PTR_INIT;
         next_st.fifo_ctl.wr_ptr = srg_pkg::FIFO_WR_PTR_INIT;
      end

      // ----------------------------------------------------------------
      // Interrupt, set wins over clear
      // ----------------------------------------------------------------
      next_st.status = (st.status & ~st_clr) | st_set;
      next_st.irq = |(next_st.status & next_st.mask);
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st.bus <= srg_pkg::SRG_BUS_IDLE;
         st.waitreq <= 1'b1;
         st.readdata <= srg_pkg::READ_ZERO;
         st.fe_clk_q <= 1'b0;
         st.be_clk_q <= 1'b0;
         st.fe_pend <= 1'b0;
         st.be_pend <= 1'b0;
         st.gain_pend <= 1'b0;
         st.acc_clr_pend <= 1'b0;
         st.acc_clr <= 1'b0;
         st.fe_cnt <= srg_pkg::CNT_ZERO;
         st.be_cnt <= srg_pkg::CNT_ZERO;
         st.fe_rst <= 1'b0;
         st.be_rst <= 1'b0;
         st.gain_strobe <= 1'b0;
         st.gain_word <= '0;
         st.acc <= '0;
         st.config_word <= srg_pkg::CONFIG_RESET;
         st.status <= '0;
         st.mask <= '0;
         st.irq <= 1'b0;
         st.be_clear <= '0;
         st.fifo_ctl <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign avs_readdata_out = st.readdata;
   assign avs_waitrequest_out = st.waitreq;
   assign front_end_reset_out = st.fe_rst;
   assign back_end_reset_out = st.be_rst;
   assign gain_load_strobe_out = st.gain_strobe;
   assign agc_acc_out = st.acc;
   assign agc_gain_out.exponent = st.acc[srg_pkg::ACC_W-1 -: srg_pkg::EXP_W];
   assign agc_gain_out.mantissa = {srg_pkg::MANT_INT,
                                   st.acc[srg_pkg::ACC_W-srg_pkg::EXP_W-1 -: srg_pkg::MANT_W]};
   assign be_clear_out = st.be_clear;
   assign fifo_ctl_out = st.fifo_ctl;
   assign irq_out = st.irq;

endmodule // srg_soft_reset

`default_nettype wire

// File: testbench/srg_soft_reset_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module srg_soft_reset_assertions (
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic front_end_clock_in,
   input wire logic back_end_clock_in,
   input wire logic avs_waitrequest_out,
   input wire logic front_end_reset_out,
   input wire logic back_end_reset_out,
   input wire logic gain_load_strobe_out,
   input wire logic [31:0] agc_acc_out,
   input wire srg_pkg::srg_gain_s agc_gain_out,
   input wire srg_pkg::srg_be_clear_s be_clear_out,
   input wire srg_pkg::srg_fifo_ctl_s fifo_ctl_out
);
   // ------------------------------
   // Edge counts during pulses
   // ------------------------------
   logic fe_q, be_q;
   logic [4:0] fcnt, bcnt, scnt;
   wire logic fe_edge = front_end_clock_in & ~fe_q;
   wire logic be_edge = back_end_clock_in & ~be_q;
   always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fe_q <= 1'h0;
         be_q <= 1'h0;
         fcnt <= 5'h00;
         bcnt <= 5'h00;
         scnt <= 5'h00;
      end else begin
         fe_q <= front_end_clock_in;
         be_q <= back_end_clock_in;
         fcnt <= front_end_reset_out ? fcnt + {4'h0, fe_edge} : 5'h00;
         bcnt <= back_end_reset_out ? bcnt + {4'h0, be_edge} : 5'h00;
         scnt <= gain_load_strobe_out ? scnt + {4'h0, be_edge} : 5'h00;
      end
   end
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_n_in);
   sequence s_take;
      (avs_read_in || avs_write_in) && avs_waitrequest_out;
   endsequence
   sequence s_answer;
      !avs_waitrequest_out ##1 avs_waitrequest_out;
   endsequence
   a_bus_answer: assert property (s_take |=> s_answer) else $error("bus answer not one cycle");
   a_bus_quiet: assert property (!(avs_read_in || avs_write_in) && avs_waitrequest_out |=> avs_waitrequest_out)
      else $error("answer without request");
   a_fe_length: assert property ($fell(front_end_reset_out) |-> fcnt == 5'h0a)
      else $error("front-end reset length wrong");
   a_be_length: assert property ($fell(back_end_reset_out) |-> bcnt == 5'h0a)
      else $error("back-end reset length wrong");
   a_strobe_length: assert property ($fell(gain_load_strobe_out) |-> scnt == 5'h01)
      else $error("gain strobe length wrong");
   a_be_clear_tie: assert property (be_clear_out == {3{back_end_reset_out}})
      else $error("back-end clears not tied to reset");
   a_fifo_preset: assert property (back_end_reset_out |-> fifo_ctl_out == 12'hf04)
      else $error("fifo preset wrong during reset");
   a_load_low: assert property (gain_load_strobe_out |-> agc_acc_out[20:0] == 21'h0_0000)
      else $error("loaded accumulator low bits not zero");
   a_gain_form: assert property (gain_load_strobe_out && $past(gain_load_strobe_out)
      |-> agc_gain_out == {agc_acc_out[31:28], 2'h1, agc_acc_out[27:21]})
      else $error("gain fields wrong");
endmodule // srg_soft_reset_assertions
bind srg_soft_reset srg_soft_reset_assertions u_chk (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
   .avs_read_in(avs_read_in), .avs_write_in(avs_write_in), .front_end_clock_in(front_end_clock_in),
   .back_end_clock_in(back_end_clock_in), .avs_waitrequest_out(avs_waitrequest_out),
   .front_end_reset_out(front_end_reset_out), .back_end_reset_out(back_end_reset_out),
   .gain_load_strobe_out(gain_load_strobe_out), .agc_acc_out(agc_acc_out), .agc_gain_out(agc_gain_out),
   .be_clear_out(be_clear_out), .fifo_ctl_out(fifo_ctl_out));
`default_nettype wire

// File: testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic ref_clk_in = 1'h0, rst_n_in = 1'h0, rd = 1'h0, wr = 1'h0, fe_clk = 1'h0, be_clk = 1'h0;
   logic [9:0] addr = 10'h000;
   logic [31:0] wdata = 32'h0000_0000, lim = 32'h0000_0000, q, d, exp_clr, rdata, acc;
   logic [3:0] tick = 4'h0;
   logic waitreq, fe_rst, be_rst, strobe, irq;
   srg_pkg::srg_gain_s gain;
   srg_pkg::srg_be_clear_s bclr;
   srg_pkg::srg_fifo_ctl_s fctl;
   int n_fail = 0, check_count = 0, seed = 32'h817a491e, c_fe, c_be, c_st, i;
   srg_soft_reset u_dut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .avs_address_in(addr),
      .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata), .avs_byteenable_in(4'hf),
      .front_end_clock_in(fe_clk), .back_end_clock_in(be_clk), .agc_limiter_in(lim),
      .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq), .front_end_reset_out(fe_rst),
      .back_end_reset_out(be_rst), .gain_load_strobe_out(strobe), .agc_acc_out(acc), .agc_gain_out(gain),
      .be_clear_out(bclr), .fifo_ctl_out(fctl), .irq_out(irq));
   initial forever #2 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      tick <= tick + 4'h1;
      fe_clk <= tick[1];
      be_clk <= tick[2];
   end
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] dv);
      int k;
      @(posedge ref_clk_in);
      rd <= ~w;
      wr <= w;
      addr <= {idx, 2'h0};
      wdata <= dv;
      k = 0;
      do begin
         @(posedge ref_clk_in);
         k++;
      end while (waitreq !== 1'b0 && k < 50);
      chk({31'h0, k < 50}, 32'h1);
      q = rdata;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask
   task automatic watch(input int n);
      c_fe = 0;
      c_be = 0;
      c_st = 0;
      repeat (n) begin
         @(negedge ref_clk_in);
         c_fe += fe_rst;
         c_be += be_rst;
         c_st += strobe;
         if (strobe === 1'b1) begin
            chk(acc, {d[15:5], 21'h0});
            chk(32'(gain), {19'h0, d[15:12], 2'h1, d[11:5]});
         end
         if (be_rst === 1'b1) begin
            chk(32'(fctl), 32'hf04);
            chk(32'(bclr), 32'h7);
            chk(acc, exp_clr);
         end
      end
   endtask
   task automatic results();
      if (n_fail == 0 && check_count > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      results();
   end
   initial begin
      repeat (10) @(posedge ref_clk_in);
      rst_n_in <= 1'h1;
      @(negedge ref_clk_in);
      chk({31'h0, waitreq}, 32'h1);
      chk(32'(fctl), 32'h0);
      bus(1'h0, srg_pkg::IDX_GAIN_LOAD, 32'h0);
      chk(q, 32'h0);
      bus(1'h0, 8'hff, 32'h0);
      chk(q, 32'h0);
      bus(1'h1, srg_pkg::IDX_MASK, 32'h4);
      bus(1'h0, srg_pkg::IDX_MASK, 32'h0);
      chk(q, 32'h4);
      for (i = 0; i < 5; i++) begin
         @(posedge ref_clk_in);
         lim <= $random(seed);
         d = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0000_001f : $random(seed);
         bus(1'h1, srg_pkg::IDX_GAIN_LOAD, d);
         watch(30);
         chk(c_st, 8);
         chk(acc, lim);
         chk({31'h0, irq}, 32'h1);
         bus(1'h0, srg_pkg::IDX_STATUS, 32'h0);
         chk({31'h0, q[2]}, 32'h1);
         bus(1'h1, srg_pkg::IDX_STATUS, 32'h4);
         repeat (2) @(negedge ref_clk_in);
         chk({31'h0, irq}, 32'h0);
      end
      for (i = 0; i < 2; i++) begin
         @(posedge ref_clk_in);
         lim <= $random(seed);
         bus(1'h1, srg_pkg::IDX_CONFIG, 32'(i) << 15);
         bus(1'h0, srg_pkg::IDX_CONFIG, 32'h0);
         chk(q, 32'(i) << 15);
         exp_clr = (i == 1) ? lim : 32'h0;
         bus(1'h1, srg_pkg::IDX_RESET_CTRL, $random(seed));
         watch(120);
         chk(c_fe, 40);
         chk(c_be, 80);
         chk(32'(fctl), 32'h704);
         bus(1'h0, srg_pkg::IDX_STATUS, 32'h0);
         chk({30'h0, q[1:0]}, 32'h3);
         bus(1'h1, srg_pkg::IDX_STATUS, 32'h3);
      end
      results();
   end
endmodule // tb_top
`default_nettype wire
